// ===== hdl/dcc_bank.sv
// die-2 odd channel configuration register bank
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_bank #(
  parameter int NCH = 8
) (
  // clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire dcc_pkg::dcc_addr_t reg_addr,
  input wire dcc_pkg::dcc_word_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output dcc_pkg::dcc_word_t reg_rdata,
  // per-channel amplifier controls, index 0..7 = channels 1,3,..,15
  output logic [NCH-1:0] amp_chain_off,
  output logic [NCH-1:0] converter_on,
  output logic [NCH*4-1:0] mixer_phase,
  output logic [NCH*5-1:0] preamp_gain_db,
  output logic [NCH-1:0] gain_code_bad
);
  import dcc_pkg::*;

  // --------------------------------
  // register storage
  // --------------------------------
  dcc_word_t pdwn_q, ph_lo_q, ph_hi_q, gain_q, ctrl_q;
  dcc_word_t rdata_q;
  logic offset_sel;
  logic ind_gain_en;
  logic [NCH*4-1:0] phase_q;
  logic [NCH*2-1:0] code_q;
  logic [NCH*5-1:0] gain_dec;
  logic [NCH-1:0] bad_dec;

  assign offset_sel = ctrl_q[`DCC_CTRL_OFFSET_BIT];
  assign ind_gain_en = ctrl_q[`DCC_CTRL_INDGAIN_BIT];

  // software writes, frozen while clk_en is low
  always_ff @(posedge clk) begin
    if (reset) begin
      pdwn_q <= `DCC_RST_VAL;
      ph_lo_q <= `DCC_RST_VAL;
      ph_hi_q <= `DCC_RST_VAL;
      gain_q <= `DCC_RST_VAL;
      ctrl_q <= `DCC_RST_VAL;
    end else if (clk_en && reg_write) begin
      case (reg_addr)
        `DCC_OFF_PDWN: pdwn_q <= reg_wdata & `DCC_PDWN_MASK;
        `DCC_OFF_PH_LO: ph_lo_q <= reg_wdata;
        `DCC_OFF_PH_HI: ph_hi_q <= reg_wdata;
        `DCC_OFF_GAIN: gain_q <= reg_wdata;
        `DCC_OFF_CTRL: ctrl_q <= reg_wdata & `DCC_CTRL_MASK;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= `DCC_RST_VAL;
    end else if (clk_en) begin
      if (reg_read) begin
        case (reg_addr)
          `DCC_OFF_PDWN: rdata_q <= pdwn_q;
          `DCC_OFF_PH_LO: rdata_q <= ph_lo_q;
          `DCC_OFF_PH_HI: rdata_q <= ph_hi_q;
          `DCC_OFF_GAIN: rdata_q <= gain_q;
          `DCC_OFF_CTRL: rdata_q <= ctrl_q;
          default: rdata_q <= `DCC_RST_VAL;
        endcase
      end else begin
        rdata_q <= `DCC_RST_VAL;
      end
    end
  end
  assign reg_rdata = rdata_q;

  // --------------------------------
  // per-channel outputs
  // --------------------------------
  // channel slot i is channel 2i+1; low four from low phase reg, upper from high
  always_comb begin
    phase_q = {ph_hi_q, ph_lo_q};
    code_q = gain_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      dcc_gain_decode u_dec (
        .code(code_q[gi*2 +: 2]),
        .gain_db(gain_dec[gi*5 +: 5]),
        .bad_code(bad_dec[gi])
      );
      // each slot shows the gain of its own field once both enables are set
      a_slot_gain: assert property (@(posedge clk) disable iff (reset)
        clk_en && offset_sel && ind_gain_en |=>
        preamp_gain_db[gi*5 +: 5] ==
        (($past(code_q[gi*2 +: 2]) == `DCC_GAIN_24DB) ? `DCC_DB24 :
        ($past(code_q[gi*2 +: 2]) == `DCC_GAIN_12DB) ? `DCC_DB12 : `DCC_DB18))
        else $error("slot gain does not match its field");
      // the unused code raises the slot flag, every other code clears it
      a_slot_flag: assert property (@(posedge clk) disable iff (reset)
        clk_en && offset_sel && ind_gain_en |=>
        gain_code_bad[gi] == ($past(code_q[gi*2 +: 2]) == `DCC_GAIN_BAD))
        else $error("unused gain code not flagged");
    end
  endgenerate

  // registered outputs; only die-2 settings act, and only with offset-select
  always_ff @(posedge clk) begin
    if (reset) begin
      amp_chain_off <= '0;
      mixer_phase <= '0;
      preamp_gain_db <= {NCH{`DCC_DB18}};
      gain_code_bad <= '0;
    end else if (clk_en) begin
      if (offset_sel) begin
        amp_chain_off <= {{(NCH-4){1'b0}}, pdwn_q[3:0]};
        mixer_phase <= phase_q;
      end
      if (offset_sel && ind_gain_en) begin
        preamp_gain_db <= gain_dec;
        gain_code_bad <= bad_dec;
      end
    end
  end

  // converter channels never follow the amplifier power-off
  assign converter_on = '1;

  // --------------------------------
  // checks
  // --------------------------------
  // power-off write taken while offset-select is set
  sequence s_write_pd;
    clk_en && reg_write && reg_addr == `DCC_OFF_PDWN && offset_sel;
  endsequence
  // phase writes taken while offset-select is set, then one enabled edge to apply
  sequence s_write_ph_lo;
    clk_en && reg_write && reg_addr == `DCC_OFF_PH_LO && offset_sel ##1 clk_en;
  endsequence
  sequence s_write_ph_hi;
    clk_en && reg_write && reg_addr == `DCC_OFF_PH_HI && offset_sel ##1 clk_en;
  endsequence
  // gain register read strobe
  sequence s_read_gain;
    clk_en && reg_read && reg_addr == `DCC_OFF_GAIN;
  endsequence

  // stored power-off bits reach the chain one enabled edge after the write
  a_pdwn_to_chain: assert property (@(posedge clk) disable iff (reset)
    s_write_pd ##1 clk_en |=> amp_chain_off[3:0] == $past(reg_wdata[3:0], 2))
    else $error("power-off bits did not reach channels");
  // only bits 3..0 are kept, the rest read back as zero
  a_pdwn_read: assert property (@(posedge clk) disable iff (reset)
    clk_en && reg_read && reg_addr == `DCC_OFF_PDWN |=> reg_rdata[15:4] == '0)
    else $error("unkept power-off bits read back");
  // slots without a power-off bit never power down
  a_chain_upper_zero: assert property (@(posedge clk) disable iff (reset)
    amp_chain_off[NCH-1:4] == '0)
    else $error("unmapped channel powered off");
  // converter side ignores the power-off bits
  a_conv_running: assert property (@(posedge clk) disable iff (reset)
    converter_on == '1)
    else $error("converter channel stopped");
  // phase outputs hold while offset-select is clear
  a_phase_hold: assert property (@(posedge clk) disable iff (reset)
    !offset_sel && clk_en |=> $stable(mixer_phase))
    else $error("phase changed without offset select");
  // power-off and gain outputs hold as well while offset-select is clear
  a_hold_no_offset: assert property (@(posedge clk) disable iff (reset)
    !offset_sel && clk_en |=> $stable(amp_chain_off) && $stable(preamp_gain_db))
    else $error("die-2 output moved without offset select");
  // low phase register lands on slots 3..0
  a_phase_low: assert property (@(posedge clk) disable iff (reset)
    s_write_ph_lo |=> mixer_phase[15:0] == $past(reg_wdata, 2))
    else $error("low phase channels wrong");
  // high phase register lands on slots 7..4
  a_phase_high: assert property (@(posedge clk) disable iff (reset)
    s_write_ph_hi |=> mixer_phase[31:16] == $past(reg_wdata, 2))
    else $error("high phase channels wrong");
  // gain register reads back what was stored
  a_gain_read: assert property (@(posedge clk) disable iff (reset)
    s_read_gain |=> reg_rdata == $past(gain_q))
    else $error("gain readback wrong");
  // code 10 in slot 0 gives 12 dB
  a_gain_decode: assert property (@(posedge clk) disable iff (reset)
    clk_en && offset_sel && ind_gain_en && gain_q[1:0] == `DCC_GAIN_12DB
    |=> preamp_gain_db[4:0] == `DCC_DB12)
    else $error("gain code 10 not 12 dB");
  // gains hold while the individual gain enable is clear
  a_gain_gated: assert property (@(posedge clk) disable iff (reset)
    !ind_gain_en |=> $stable(preamp_gain_db))
    else $error("gain moved without enable");
  // read data stands only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    clk_en && !reg_read |=> reg_rdata == '0)
    else $error("read data outside its cycle");
  // reads of addresses outside the map return zero
  a_read_unmapped: assert property (@(posedge clk) disable iff (reset)
    clk_en && reg_read && !(reg_addr inside {`DCC_OFF_PDWN, `DCC_OFF_PH_LO, `DCC_OFF_PH_HI,
      `DCC_OFF_GAIN, `DCC_OFF_CTRL}) |=> reg_rdata == '0)
    else $error("unmapped read returned data");
  // clock enable low freezes registers and outputs
  a_freeze_all: assert property (@(posedge clk) disable iff (reset)
    !clk_en |=> $stable(amp_chain_off) && $stable(mixer_phase) && $stable(preamp_gain_db)
      && $stable(reg_rdata) && $stable(pdwn_q) && $stable(ctrl_q) && $stable(gain_q))
    else $error("state moved while clock enable was low");
endmodule

// ===== common/dcc_map.svh
// register offsets, field positions, reset values for the die-2 channel config bank
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
`define DCC_ADDR_W 8
`define DCC_OFF_PDWN 8'hd5
`define DCC_OFF_PH_LO 8'hd7
`define DCC_OFF_PH_HI 8'hd8
`define DCC_OFF_GAIN 8'hd9
`define DCC_OFF_CTRL 8'he0
`define DCC_CTRL_OFFSET_BIT 0
`define DCC_CTRL_INDGAIN_BIT 1
`define DCC_CTRL_MASK 16'h0003
`define DCC_PDWN_MASK 16'h000f
`define DCC_RST_VAL 16'h0000
`define DCC_PHASE_STEP_CENTIDEG 2250
`define DCC_GAIN_18DB 2'h0
`define DCC_GAIN_24DB 2'h1
`define DCC_GAIN_12DB 2'h2
`define DCC_GAIN_BAD 2'h3
`define DCC_DB18 5'h12
`define DCC_DB24 5'h18
`define DCC_DB12 5'h0c
`endif

// ===== common/dcc_pkg.sv
// types shared by the die-2 channel config bank
package dcc_pkg;
  typedef logic [15:0] dcc_word_t;
  typedef logic [7:0] dcc_addr_t;
  typedef enum logic [1:0] {
    DCC_G18 = 2'b00,
    DCC_G24 = 2'b01,
    DCC_G12 = 2'b10,
    DCC_GNU = 2'b11
  } dcc_gain_t;
endpackage

// ===== hdl/dcc_gain_decode.sv
// decodes one 2-bit preamp gain field into gain in dB
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_gain_decode (
  // field in
  input wire logic [1:0] code,
  // decoded gain
  output logic [4:0] gain_db,
  output logic bad_code
);
  import dcc_pkg::*;
  // map code to dB, the unused code falls back to 18 dB
  always_comb begin
    bad_code = 1'b0;
    case (dcc_gain_t'(code))
      DCC_G18: gain_db = 5'h12;
      DCC_G24: gain_db = 5'h18;
      DCC_G12: gain_db = 5'h0c;
      default: begin
        gain_db = 5'h12;
        bad_code = 1'b1;
      end
    endcase
  end
endmodule

// ===== tb/dcc_bank_bench.sv
// self-checking bench for the die-2 channel config bank
`timescale 1ns/1ps
module dcc_bank_bench;
  import dcc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  dcc_addr_t reg_addr = 8'h00;
  dcc_word_t reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  dcc_word_t reg_rdata;
  logic [7:0] amp_chain_off, converter_on, gain_code_bad, exp_b;
  logic [31:0] mixer_phase;
  logic [39:0] preamp_gain_db, exp_g;
  int num_errors = 0;
  int checks_done = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  dcc_bank DUT (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .amp_chain_off(amp_chain_off), .converter_on(converter_on),
    .mixer_phase(mixer_phase), .preamp_gain_db(preamp_gain_db),
    .gain_code_bad(gain_code_bad));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe, ends on the taking edge
  task automatic wr(input dcc_addr_t a, input dcc_word_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // read strobe, data compared in the following cycle
  task automatic rd(input dcc_addr_t a, input dcc_word_t exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk({24'h0, reg_rdata}, {24'h0, exp});
  endtask
  // channel outputs land one edge after the write
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  // expected slot gains from a gain word: 01 24 dB, 10 12 dB, else 18 dB; 11 flagged
  task automatic gexp(input dcc_word_t w);
    for (int i = 0; i < 8; i++) begin
      exp_g[5*i+:5] = (w[2*i+:2] == 2'h1) ? 5'h18 : (w[2*i+:2] == 2'h2) ? 5'h0c : 5'h12;
      exp_b[i] = (w[2*i+:2] == 2'h3);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    gexp(16'h0000);
    rd(8'hd9, 16'h0000);
    rd(8'hd7, 16'h0000);
    rd(8'hd8, 16'h0000);
    chk(preamp_gain_db, exp_g);
    wr(8'hd5, 16'hffff);
    settle();
    chk(amp_chain_off, 40'h0);
    wr(8'he0, 16'h0001);
    settle();
    chk(amp_chain_off, 40'h0f);
    chk(converter_on, 40'hff);
    rd(8'hd5, 16'h000f);
    wr(8'hd5, 16'h0005);
    settle();
    chk(amp_chain_off, 40'h05);
    wr(8'hd7, 16'hf05a);
    wr(8'hd8, 16'h1c93);
    settle();
    chk(mixer_phase, 40'h1c93f05a);
    rd(8'hd6, 16'h0000);
    wr(8'hd9, 16'he4e4);
    settle();
    chk(preamp_gain_db, exp_g);
    wr(8'he0, 16'h0003);
    settle();
    gexp(16'he4e4);
    chk(preamp_gain_db, exp_g);
    chk(gain_code_bad, exp_b);
    rd(8'hd9, 16'he4e4);
    wr(8'hd9, 16'h1e1e);
    settle();
    gexp(16'h1e1e);
    chk(preamp_gain_db, exp_g);
    chk(gain_code_bad, exp_b);
    // a write while the clock enable is low must be lost
    clk_en <= 1'b0;
    wr(8'hd7, 16'h0000);
    clk_en <= 1'b1;
    settle();
    chk(mixer_phase, 40'h1c93f05a);
    rd(8'hd7, 16'hf05a);
    wr(8'he0, 16'h0000);
    wr(8'hd7, 16'h0000);
    wr(8'hd5, 16'h0000);
    settle();
    chk(mixer_phase, 40'h1c93f05a);
    chk(amp_chain_off, 40'h05);
    // reset in mid-run zeroes the registers and outputs, the slot gains go back to 18 dB
    reset <= 1'b1;
    repeat (2) settle();
    reset <= 1'b0;
    gexp(16'h0000);
    rd(8'hd9, 16'h0000);
    chk(preamp_gain_db, exp_g);
    chk(mixer_phase, 40'h0);
    chk(amp_chain_off, 40'h0);
    end_sim();
  end
endmodule
